// ---- flash_host_pkg.sv ----
// Constants, types and register map for the serial flash host controller.
// Assumes an AXI4-Lite master with 32-bit data and a flash device on a dual-line serial link.
// Summary of operation
// - Host drives protect pin high to leave hardware lock; high pin never locks.
// - Basic read: opcode, 3 address bytes on serial_in, data on falling edges.
// - Host may raise chip select during data to end the read.
// - Fast read: opcode, 3 address bytes, one dummy byte, then data.
// - Dual-edge read: opcode single, address 2 bits per clock, 6 dummy clocks.
// - Dual-edge read carries one bit on rising and next on falling edge.
// - Dual I/O read: address on two lines, 4 dummy cycles, 2-bit data.
// - Dual I/O dual-edge read: 4 bits per clock, 6 dummy clocks.
// - Dual I/O dual-edge read: two bits per edge for address and data.
// - Opcode always goes one bit per clock on a single line.
// - Host sends write enable before every status write; this host issues read frames only and has no status write.
package flash_host_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] ADDR_OFFSET = 8'h04;
   localparam logic [7:0] OPC_OFFSET = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0C;
   localparam logic [7:0] DATA_OFFSET = 8'h10;
   localparam logic [7:0] DIV_OFFSET = 8'h14;
   // Control and status field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_PROTECT_BIT = 4;
   localparam int CTRL_STOP_BIT = 5;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_VALID_BIT = 1;
   localparam int STATUS_PIN_BIT = 2;
   // Reset values and response codes
   localparam logic [7:0] OPC_RESET = 8'h03;
   localparam logic [7:0] DIV_RESET = 8'h04;
   localparam logic [31:0] AXI_RESP_OKAY = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing counts in link clocks and address bits
   localparam logic [3:0] FAST_DUMMY_CLOCKS = 4'h8;
   localparam logic [3:0] DTR_DUMMY_CLOCKS = 4'h6;
   localparam logic [3:0] DUAL_DUMMY_CLOCKS = 4'h4;
   localparam logic [3:0] DUAL_DTR_DUMMY_CLOCKS = 4'h6;
   localparam logic [5:0] ADDR_BITS = 6'h18;

   typedef enum logic [2:0]
   {
      READ_BASIC,
      READ_FAST,
      READ_FAST_DTR,
      READ_DUAL_IO,
      READ_DUAL_IO_DTR
   } read_mode_t;

   typedef struct packed
   {
      logic cs_n;
      logic sclk;
      logic [1:0] io_out;
      logic [1:0] io_oe_n;
      logic protect_n;
   } flash_pins_t;
endpackage : flash_host_pkg

// ---- link_clock_divider.sv ----
// Link clock generator for the flash host.
// Assumes a clock enable that freezes it and a nonzero half-period count.
`timescale 1ns/100ps
module link_clock_divider #(
   parameter int DIV_WIDTH = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic run,
   input wire logic [DIV_WIDTH-1:0] half_period,
   output logic sclk,
   output logic rise,
   output logic fall
);
   typedef struct packed
   {
      logic [DIV_WIDTH-1:0] count;
      logic sclk;
   } div_state_t;

   div_state_t state_reg;
   div_state_t state_next;
   logic tick;

   assign tick = run && (state_reg.count + DIV_WIDTH'(1) >= half_period);
   assign sclk = state_reg.sclk;
   // Edges announced one cycle ahead so the shifter acts with the clock
   assign rise = tick && !state_reg.sclk;
   assign fall = tick && state_reg.sclk;

   always_comb
   begin
      state_next = state_reg;
      if (!run)
      begin
         state_next.count = '0;
         state_next.sclk = 1'b0;
      end
      else if (tick)
      begin
         state_next.count = '0;
         state_next.sclk = !state_reg.sclk;
      end
      else
      begin
         state_next.count = state_reg.count + DIV_WIDTH'(1);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= '0;
      end
      else if (ce)
      begin
         state_reg <= state_next;
      end
   end
endmodule : link_clock_divider

// ---- flash_read_host.sv ----
// Host controller issuing read commands to a serial flash and driving its protect pin.
// Assumes an AXI4-Lite master and a flash device that samples on link clock edges.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module flash_read_host (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic chip_select_n,
   output logic serial_clock,
   input wire logic [1:0] io_in,
   output logic [1:0] io_out,
   output logic [1:0] io_oe_n,
   output logic write_protect_pin
);
   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_DUMMY,
      ST_DATA,
      ST_END
   } phase_t;

   typedef struct packed
   {
      phase_t phase;
      flash_host_pkg::read_mode_t mode;
      logic [7:0] opcode;
      logic [23:0] addr;
      logic [31:0] shift;
      logic [5:0] bits_left;
      logic [3:0] dummy_left;
      logic [7:0] rx_byte;
      logic [3:0] rx_count;
      logic [7:0] data;
      logic data_valid;
      logic [7:0] div;
      logic protect;
      logic stop;
      logic start;
      flash_host_pkg::flash_pins_t pins;
      logic [1:0] io_meta;
      logic [1:0] io_sync;
      logic aw_taken;
      logic w_taken;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } host_state_t;

   host_state_t state_reg;
   host_state_t state_next;
   logic link_run;
   logic sclk_rise;
   logic sclk_fall;
   logic sclk_level;

   // Bits moved per link edge, by mode
   function automatic logic [2:0] lane_width(input flash_host_pkg::read_mode_t m);
      case (m)
         flash_host_pkg::READ_DUAL_IO, flash_host_pkg::READ_DUAL_IO_DTR: lane_width = 3'h2;
         default: lane_width = 3'h1;
      endcase
   endfunction : lane_width

   function automatic logic is_dtr(input flash_host_pkg::read_mode_t m);
      is_dtr = (m == flash_host_pkg::READ_FAST_DTR) || (m == flash_host_pkg::READ_DUAL_IO_DTR);
   endfunction : is_dtr

   function automatic logic [3:0] dummy_count(input flash_host_pkg::read_mode_t m);
      case (m)
         flash_host_pkg::READ_FAST: dummy_count = flash_host_pkg::FAST_DUMMY_CLOCKS;
         flash_host_pkg::READ_FAST_DTR: dummy_count = flash_host_pkg::DTR_DUMMY_CLOCKS;
         flash_host_pkg::READ_DUAL_IO: dummy_count = flash_host_pkg::DUAL_DUMMY_CLOCKS;
         flash_host_pkg::READ_DUAL_IO_DTR: dummy_count = flash_host_pkg::DUAL_DTR_DUMMY_CLOCKS;
         default: dummy_count = 4'h0;
      endcase
   endfunction : dummy_count

   link_clock_divider #(
      .DIV_WIDTH(8)
   ) u_divider (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .run(link_run),
      .half_period(state_reg.div),
      .sclk(sclk_level),
      .rise(sclk_rise),
      .fall(sclk_fall)
   );

   // Clock runs for the whole frame; stopping it mid-opcode would stall the sequencer
   assign link_run = (state_reg.phase != ST_IDLE) && (state_reg.phase != ST_END);

   assign chip_select_n = state_reg.pins.cs_n;
   assign serial_clock = sclk_level;
   assign io_out = state_reg.pins.io_out;
   assign io_oe_n = state_reg.pins.io_oe_n;
   assign write_protect_pin = state_reg.pins.protect_n;
   assign s_axi_awready = !state_reg.aw_taken && !state_reg.bvalid;
   assign s_axi_wready = !state_reg.w_taken && !state_reg.bvalid;
   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_bresp = state_reg.bresp;
   assign s_axi_arready = !state_reg.rvalid;
   assign s_axi_rvalid = state_reg.rvalid;
   assign s_axi_rdata = state_reg.rdata;
   assign s_axi_rresp = state_reg.rresp;

   always_comb
   begin
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [2:0] w;
      logic edge_out;
      logic edge_in;
      logic [7:0] nb;
      waddr = '0;
      wdata = '0;
      w = lane_width(state_reg.mode);
      edge_out = is_dtr(state_reg.mode) ? (sclk_rise || sclk_fall) : sclk_fall;
      edge_in = is_dtr(state_reg.mode) ? (sclk_rise || sclk_fall) : sclk_rise;
      nb = state_reg.rx_byte;
      state_next = state_reg;
      state_next.io_meta = io_in;
      state_next.io_sync = state_reg.io_meta;
      state_next.start = 1'b0;
      // Protect level reaches the pin inverted, one clock later through the pin register; lock exits only when driven high
      state_next.pins.protect_n = !state_reg.protect;

      // AXI write channel
      if (s_axi_awvalid && s_axi_awready)
      begin
         state_next.aw_taken = 1'b1;
         state_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         state_next.w_taken = 1'b1;
         state_next.w_data = s_axi_wdata;
      end
      if (state_reg.aw_taken && state_reg.w_taken)
      begin
         waddr = state_reg.aw_addr;
         wdata = state_reg.w_data;
         state_next.aw_taken = 1'b0;
         state_next.w_taken = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = flash_host_pkg::RESP_OKAY;
         case (waddr)
            flash_host_pkg::CTRL_OFFSET:
            begin
               state_next.start = wdata[flash_host_pkg::CTRL_START_BIT];
               state_next.protect = wdata[flash_host_pkg::CTRL_PROTECT_BIT];
               state_next.stop = wdata[flash_host_pkg::CTRL_STOP_BIT];
               if (state_reg.phase == ST_IDLE)
               begin
                  state_next.mode = flash_host_pkg::read_mode_t'(
                     wdata[flash_host_pkg::CTRL_MODE_LSB +: 3]);
               end
            end
            flash_host_pkg::ADDR_OFFSET:
            begin
               if (state_reg.phase == ST_IDLE)
               begin
                  state_next.addr = wdata[23:0];
               end
            end
            flash_host_pkg::OPC_OFFSET: state_next.opcode = wdata[7:0];
            flash_host_pkg::DIV_OFFSET:
            begin
               state_next.div = (wdata[7:0] == 8'h00) ? 8'h01 : wdata[7:0];
            end
            flash_host_pkg::STATUS_OFFSET, flash_host_pkg::DATA_OFFSET: ;
            default: state_next.bresp = flash_host_pkg::RESP_SLVERR;
         endcase
      end
      if (state_reg.bvalid && s_axi_bready)
      begin
         state_next.bvalid = 1'b0;
      end

      // AXI read channel; a data read consumes the byte
      if (s_axi_arvalid && s_axi_arready)
      begin
         state_next.rvalid = 1'b1;
         state_next.rresp = flash_host_pkg::RESP_OKAY;
         state_next.rdata = '0;
         case (s_axi_araddr)
            flash_host_pkg::CTRL_OFFSET:
            begin
               state_next.rdata[flash_host_pkg::CTRL_MODE_LSB +: 3] = state_reg.mode;
               state_next.rdata[flash_host_pkg::CTRL_PROTECT_BIT] = state_reg.protect;
            end
            flash_host_pkg::ADDR_OFFSET: state_next.rdata[23:0] = state_reg.addr;
            flash_host_pkg::OPC_OFFSET: state_next.rdata[7:0] = state_reg.opcode;
            flash_host_pkg::STATUS_OFFSET:
            begin
               state_next.rdata[flash_host_pkg::STATUS_BUSY_BIT] = state_reg.phase != ST_IDLE;
               state_next.rdata[flash_host_pkg::STATUS_VALID_BIT] = state_reg.data_valid;
               state_next.rdata[flash_host_pkg::STATUS_PIN_BIT] = state_reg.pins.protect_n;
            end
            flash_host_pkg::DATA_OFFSET:
            begin
               state_next.rdata[7:0] = state_reg.data;
               state_next.data_valid = 1'b0;
            end
            flash_host_pkg::DIV_OFFSET: state_next.rdata[7:0] = state_reg.div;
            default: state_next.rresp = flash_host_pkg::RESP_SLVERR;
         endcase
      end
      if (state_reg.rvalid && s_axi_rready)
      begin
         state_next.rvalid = 1'b0;
      end

      // Link sequencer
      case (state_reg.phase)
         ST_IDLE:
         begin
            state_next.pins.cs_n = 1'b1;
            state_next.pins.io_oe_n = 2'h3;
            if (state_reg.start)
            begin
               state_next.pins.cs_n = 1'b0;
               state_next.pins.io_oe_n = 2'h2;
               state_next.pins.io_out = {1'b0, state_reg.opcode[7]};
               state_next.shift = {state_reg.opcode[6:0], 25'h0};
               state_next.bits_left = 6'h07;
               state_next.stop = 1'b0;
               state_next.data_valid = 1'b0;
               state_next.phase = ST_OPCODE;
            end
         end
         ST_OPCODE:
         begin
            // Opcode always single line, one bit per clock
            if (sclk_fall)
            begin
               if (state_reg.bits_left != 6'h0)
               begin
                  state_next.pins.io_out = {1'b0, state_reg.shift[31]};
                  state_next.shift = {state_reg.shift[30:0], 1'b0};
                  state_next.bits_left = state_reg.bits_left - 6'h01;
               end
               else
               begin
                  state_next.shift = {state_reg.addr, 8'h00};
                  state_next.bits_left = flash_host_pkg::ADDR_BITS;
                  state_next.phase = ST_ADDR;
                  if (w == 3'h2)
                  begin
                     state_next.pins.io_oe_n = 2'h0;
                     state_next.pins.io_out = state_reg.addr[23:22];
                     state_next.shift = {state_reg.addr[21:0], 10'h0};
                     state_next.bits_left = flash_host_pkg::ADDR_BITS - 6'h02;
                  end
                  else
                  begin
                     state_next.pins.io_out = {1'b0, state_reg.addr[23]};
                     state_next.shift = {state_reg.addr[22:0], 9'h0};
                     state_next.bits_left = flash_host_pkg::ADDR_BITS - 6'h01;
                  end
               end
            end
         end
         ST_ADDR:
         begin
            // Address shifts on falling edges, or both edges in dual-edge modes
            if (edge_out)
            begin
               if (state_reg.bits_left != 6'h0)
               begin
                  if (w == 3'h2)
                  begin
                     state_next.pins.io_out = state_reg.shift[31:30];
                     state_next.shift = {state_reg.shift[29:0], 2'h0};
                     state_next.bits_left = state_reg.bits_left - 6'h02;
                  end
                  else
                  begin
                     state_next.pins.io_out = {1'b0, state_reg.shift[31]};
                     state_next.shift = {state_reg.shift[30:0], 1'b0};
                     state_next.bits_left = state_reg.bits_left - 6'h01;
                  end
               end
               else
               begin
                  state_next.dummy_left = dummy_count(state_reg.mode);
                  state_next.rx_count = 4'h0;
                  state_next.rx_byte = 8'h00;
                  state_next.pins.io_out = 2'h0;
                  // Dual modes release both lines so the device can take over
                  state_next.pins.io_oe_n = (w == 3'h2) ? 2'h3 : 2'h2;
                  state_next.phase = (dummy_count(state_reg.mode) == 4'h0) ? ST_DATA : ST_DUMMY;
               end
            end
         end
         ST_DUMMY:
         begin
            // Dummy counted in link clocks, on the rising edge
            if (sclk_rise)
            begin
               state_next.dummy_left = state_reg.dummy_left - 4'h1;
               if (state_reg.dummy_left == 4'h1)
               begin
                  state_next.phase = ST_DATA;
               end
            end
         end
         ST_DATA:
         begin
            if (edge_in)
            begin
               if (w == 3'h2)
               begin
                  nb = {state_reg.rx_byte[5:0], state_reg.io_sync};
               end
               else
               begin
                  nb = {state_reg.rx_byte[6:0], state_reg.io_sync[1]};
               end
               state_next.rx_byte = nb;
               state_next.rx_count = state_reg.rx_count + {1'b0, w};
               if (state_reg.rx_count + {1'b0, w} >= 4'h8)
               begin
                  state_next.data = nb;
                  state_next.data_valid = 1'b1;
                  state_next.rx_count = 4'h0;
                  state_next.addr = state_reg.addr + 24'h000001;
                  if (state_reg.stop)
                  begin
                     state_next.phase = ST_END;
                  end
               end
            end
            if (state_reg.stop && state_reg.rx_count == 4'h0 && !edge_in)
            begin
               state_next.phase = ST_END;
            end
         end
         ST_END:
         begin
            state_next.pins.cs_n = 1'b1;
            state_next.pins.io_oe_n = 2'h3;
            state_next.phase = ST_IDLE;
         end
         default: state_next.phase = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= '0;
         state_reg.phase <= ST_IDLE;
         state_reg.mode <= flash_host_pkg::READ_BASIC;
         state_reg.opcode <= flash_host_pkg::OPC_RESET;
         state_reg.div <= flash_host_pkg::DIV_RESET;
         state_reg.pins.cs_n <= 1'b1;
         state_reg.pins.io_oe_n <= 2'h3;
         state_reg.pins.protect_n <= 1'b1;
      end
      else if (ce)
      begin
         state_reg <= state_next;
      end
   end
endmodule : flash_read_host

// ---- flash_read_host_sva.sv ----
// Checker for the flash read host: link framing and the AXI read channel.
// Assumes only the host's own ports; bound to every host instance.
`timescale 1ns/100ps
module flash_read_host_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic chip_select_n,
   input wire logic serial_clock,
   input wire logic [1:0] io_oe_n
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence quiet_frame;
      chip_select_n ##1 chip_select_n;
   endsequence
   sequence frame_open;
      $fell(chip_select_n);
   endsequence
   AST_RESET_IDLE: assert property ($rose(aresetn) |-> chip_select_n && io_oe_n == 2'b11)
      else $error("host not idle after reset");
   AST_LINK_QUIET: assert property (quiet_frame |-> !serial_clock)
      else $error("link clock runs outside a frame");
   AST_EDGE_IN_FRAME: assert property ($rose(serial_clock) |-> !chip_select_n)
      else $error("link clock edge without select");
   AST_OPEN_LOW: assert property (frame_open |-> !serial_clock)
      else $error("frame opened with clock high");
   AST_OPCODE_DRIVE: assert property (frame_open |-> ##[0:2] !io_oe_n[0])
      else $error("opcode line not driven");
   AST_RELEASE_IDLE: assert property (quiet_frame |-> io_oe_n == 2'b11)
      else $error("data lines driven outside a frame");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
      else $error("read answer dropped");
   AST_READ_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
endmodule : flash_read_host_sva

bind flash_read_host flash_read_host_sva checker_inst (.aclk, .aresetn, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .chip_select_n,
   .serial_clock, .io_oe_n);

// ---- flash_device_model.sv ----
// Behavioural flash device for single-line reads; array byte is a function of address.
// Assumes mode 0 link timing and a dummy count set by the bench before each frame.
`timescale 1ns/100ps
module flash_device_model (
   input wire logic chip_select_n,
   input wire logic serial_clock,
   input wire logic [1:0] link_io,
   input wire logic [3:0] dummy_clocks,
   input wire logic write_protect_pin,
   output logic [1:0] dev_io,
   output logic [7:0] opcode_seen,
   output logic [23:0] addr_seen
);
   logic hw_lock;
   logic so = 1'b0;
   logic [31:0] shift = 32'h0;
   logic [7:0] b;
   int edges = 0;
   int n;
   function automatic logic [7:0] byte_at(input logic [23:0] a);
      return a[7:0] ^ a[23:16] ^ 8'hA5;
   endfunction : byte_at
   // Lock bit held at one, so the pin alone picks the mode
   assign hw_lock = !write_protect_pin;
   // Released line toggles, so a stale bit never passes
   assign dev_io = {so, ~so};
   always @(negedge chip_select_n)
      edges = 0;
   always @(posedge chip_select_n)
      so = ~so;
   always @(posedge serial_clock)
      if (!chip_select_n)
      begin
         shift = {shift[30:0], link_io[0]};
         edges++;
         if (edges == 8)
            opcode_seen = shift[7:0];
         if (edges == 32)
            addr_seen = shift[23:0];
      end
   always @(negedge serial_clock)
      if (!chip_select_n)
      begin
         n = edges - 32 - int'(dummy_clocks);
         b = byte_at(addr_seen + 24'(n / 8));
         if (n >= 0)
            so = b[3'(7 - n % 8)];
         else
            so = ~so;
      end
endmodule : flash_device_model

// ---- flash_read_host_tb.sv ----
// Testbench for the flash read host: registers, protect pin and every read mode.
// Assumes the behavioural flash model on the link; data checked in basic and fast reads only.
`timescale 1ns/100ps
module flash_read_host_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp, s_axi_bresp;
   logic chip_select_n, serial_clock, write_protect_pin;
   logic [1:0] io_in, io_out, io_oe_n, dev_io;
   logic [7:0] opcode_seen, opc;
   logic [23:0] addr_seen, start;
   logic [3:0] dummy = 4'h0;
   logic [31:0] seed = 32'h45;
   logic [31:0] rd;
   int mismatches = 0;
   int tests_run = 0;
   always #10 aclk = ~aclk;
   assign io_in[0] = io_oe_n[0] ? dev_io[0] : io_out[0];
   assign io_in[1] = io_oe_n[1] ? dev_io[1] : io_out[1];
   flash_read_host uut (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .chip_select_n, .serial_clock, .io_in, .io_out, .io_oe_n, .write_protect_pin);
   flash_device_model model (.chip_select_n, .serial_clock, .link_io(io_in),
      .dummy_clocks(dummy), .write_protect_pin, .dev_io, .opcode_seen, .addr_seen);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] byte_at(input logic [23:0] a);
      return a[7:0] ^ a[23:16] ^ 8'hA5;
   endfunction : byte_at
   task automatic report_and_stop;
      if (mismatches == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check_word
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      logic [2:0] p;
      int n;
      p = 3'b111;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= p;
      while (p[0] && n < 99)
      begin
         @(posedge aclk);
         p[0] = !(s_axi_bvalid && p[2:1] == 2'b00);
         p[2] = p[2] && !s_axi_awready;
         p[1] = p[1] && !s_axi_wready;
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= p;
         n++;
      end
      @(posedge aclk);
      check_word("write wait", 32'h0, 32'(p[0]));
      check_word("write resp", 32'(flash_host_pkg::RESP_OKAY), 32'(s_axi_bresp));
      if (p[0])
         report_and_stop();
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a);
      logic [1:0] p;
      int n;
      p = 2'b11;
      n = 0;
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= p;
      while (p[0] && n < 99)
      begin
         @(posedge aclk);
         rd = s_axi_rdata;
         p[0] = !(s_axi_rvalid && !p[1]);
         p[1] = p[1] && !s_axi_arready;
         {s_axi_arvalid, s_axi_rready} <= p;
         n++;
      end
      @(posedge aclk);
      check_word("read wait", 32'h0, 32'(p[0]));
      if (p[0])
         report_and_stop();
   endtask : axi_read
   task automatic wait_status(input int pos, input logic val);
      int n;
      n = 0;
      axi_read(flash_host_pkg::STATUS_OFFSET);
      while (rd[pos] !== val && n < 400)
      begin
         axi_read(flash_host_pkg::STATUS_OFFSET);
         n++;
      end
      check_word("status wait", 32'(val), 32'(rd[pos]));
      if (rd[pos] !== val)
         report_and_stop();
   endtask : wait_status
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_read(flash_host_pkg::OPC_OFFSET);
      check_word("opcode reset", 32'(flash_host_pkg::OPC_RESET), rd);
      axi_read(flash_host_pkg::DIV_OFFSET);
      check_word("divider reset", 32'(flash_host_pkg::DIV_RESET), rd);
      axi_read(8'h18);
      check_word("unmapped resp", 32'(flash_host_pkg::RESP_SLVERR), 32'(s_axi_rresp));
      for (int p = 1; p >= 0; p--)
      begin
         axi_write(flash_host_pkg::CTRL_OFFSET, 32'(p) << flash_host_pkg::CTRL_PROTECT_BIT);
         check_word("protect pin", 32'(1 - p), 32'(write_protect_pin));
      end
      // Mode 0 starts two bytes below the top to cross the wrap
      for (int m = 0; m < 5; m++)
      begin
         seed = lfsr(seed);
         opc = seed[7:0];
         start = (m == 0) ? 24'hFFFFFE : seed[31:8];
         dummy <= (m == 1) ? flash_host_pkg::FAST_DUMMY_CLOCKS : 4'h0;
         axi_write(flash_host_pkg::OPC_OFFSET, 32'(opc));
         axi_write(flash_host_pkg::ADDR_OFFSET, 32'(start));
         axi_write(flash_host_pkg::CTRL_OFFSET, (32'(m) << flash_host_pkg::CTRL_MODE_LSB) | 32'h1);
         for (int k = 0; k < 3; k++)
         begin
            wait_status(flash_host_pkg::STATUS_VALID_BIT, 1'b1);
            axi_read(flash_host_pkg::DATA_OFFSET);
            if (m < 2)
               check_word("data", 32'(byte_at(start + 24'(k))), 32'(rd[7:0]));
         end
         check_word("opcode on link", 32'(opc), 32'(opcode_seen));
         if (m < 2)
            check_word("address on link", 32'(start), 32'(addr_seen));
         axi_write(flash_host_pkg::CTRL_OFFSET, 32'h1 << flash_host_pkg::CTRL_STOP_BIT);
         wait_status(flash_host_pkg::STATUS_BUSY_BIT, 1'b0);
         check_word("select after stop", 32'h1, 32'(chip_select_n));
         // Drop the byte left over after stop
         axi_read(flash_host_pkg::DATA_OFFSET);
      end
      report_and_stop();
   end
endmodule : flash_read_host_tb
